// [csf_status_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "csf_status_cfg.svh"

// Operation
// - Bit 7 shows second blocking pair fitted.
// - Bit 6 shows first blocking pair fitted.
// - Bit 5 shows one-shot conversion complete.
// - Bit 4 shows forward minimum system regulation.
// - Bit 3 shows fast charge timer expired.
// - Bit 2 shows trickle timer expired.
// - Bit 1 shows pre-charge timer expired.
// - Zone bit 3 shows cold zone.
// - Zone bit 2 shows cool zone.
// - Zone bit 1 shows warm zone.
// - Zone bit 0 shows hot zone.
// - Fault bit 7 shows discharge current regulation.
// - Fault bit 6 shows input bus overvoltage.
// - Fault bit 5 shows battery overvoltage.
// - Fault bit 4 shows input bus overcurrent.
// - Fault bit 3 shows battery overcurrent.
// - Fault bit 2 shows converter overcurrent.
// - Fault bit 1 shows second alternate input overvoltage.
// - All three registers read-only, reset zero.
// - Fault bit 0 shows first alternate input overvoltage.
module csf_status_regs (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Register access port behind the serial host interface.
   input  wire logic       reg_rd_en,
   input  wire logic       reg_wr_en,
   input  wire logic [7:0] reg_addr,
   output var  logic [7:0] reg_rd_data_q,
   output var  logic       reg_ack_q,
   output var  logic       reg_err_q,
   // Live conditions for the first status register.
   input  wire logic       input2_blocking_pair_fitted,
   input  wire logic       input1_blocking_pair_fitted,
   input  wire logic       adc_one_shot_mode,
   input  wire logic       adc_conversion_complete,
   input  wire logic       converter_forward_mode,
   input  wire logic       min_system_regulation_active,
   input  wire logic       fast_charge_timer_expired,
   input  wire logic       trickle_timer_expired,
   input  wire logic       precharge_timer_expired,
   // Live thermistor zone conditions.
   input  wire logic       thermistor_cold_zone,
   input  wire logic       thermistor_cool_zone,
   input  wire logic       thermistor_warm_zone,
   input  wire logic       thermistor_hot_zone,
   // Live fault and regulation conditions.
   input  wire logic       discharge_current_regulating,
   input  wire logic       input_bus_overvoltage,
   input  wire logic       battery_overvoltage,
   input  wire logic       input_bus_overcurrent,
   input  wire logic       battery_overcurrent,
   input  wire logic       converter_overcurrent,
   input  wire logic       alt_input2_overvoltage,
   input  wire logic       alt_input1_overvoltage,
   // Register images, offered for observation on the status outputs.
   output var  logic [7:0] charger_status_three_q,
   output var  logic [7:0] thermistor_zone_status_q,
   output var  logic [7:0] fault_status_zero_q
);

   // Next value of the first status register.
   logic [7:0] charger_status_three_d;
   // Next value of the thermistor zone register.
   logic [7:0] thermistor_zone_status_d;
   // Next value of the first fault status register.
   logic [7:0] fault_status_zero_d;

   // Assemble the first status register from live conditions.
   always_comb begin
      // Start from zero so the reserved bit stays clear.
      charger_status_three_d = `CSF_RESET_VALUE;
      charger_status_three_d[`CSF_S3_PAIR2_BIT] = input2_blocking_pair_fitted;
      charger_status_three_d[`CSF_S3_PAIR1_BIT] = input1_blocking_pair_fitted;
      // Completion only counts while the converter is in one-shot mode.
      charger_status_three_d[`CSF_S3_ADC_DONE_BIT] = adc_one_shot_mode & adc_conversion_complete;
      // Minimum system regulation is reported in forward mode only.
      charger_status_three_d[`CSF_S3_MIN_SYS_BIT] = converter_forward_mode & min_system_regulation_active;
      charger_status_three_d[`CSF_S3_FAST_TMR_BIT] = fast_charge_timer_expired;
      charger_status_three_d[`CSF_S3_TRICKLE_BIT] = trickle_timer_expired;
      charger_status_three_d[`CSF_S3_PRECHG_BIT] = precharge_timer_expired;
   end

   // Assemble the thermistor zone register from live zone flags.
   always_comb begin
      // The upper nibble is reserved and stays clear.
      thermistor_zone_status_d = `CSF_RESET_VALUE;
      thermistor_zone_status_d[`CSF_TZ_COLD_BIT] = thermistor_cold_zone;
      thermistor_zone_status_d[`CSF_TZ_COOL_BIT] = thermistor_cool_zone;
      thermistor_zone_status_d[`CSF_TZ_WARM_BIT] = thermistor_warm_zone;
      thermistor_zone_status_d[`CSF_TZ_HOT_BIT]  = thermistor_hot_zone;
   end

   // Assemble the first fault status register from live fault flags.
   always_comb begin
      fault_status_zero_d = `CSF_RESET_VALUE;
      fault_status_zero_d[`CSF_F0_DIS_REG_BIT] = discharge_current_regulating;
      fault_status_zero_d[`CSF_F0_BUS_OV_BIT]  = input_bus_overvoltage;
      fault_status_zero_d[`CSF_F0_BAT_OV_BIT]  = battery_overvoltage;
      fault_status_zero_d[`CSF_F0_BUS_OC_BIT]  = input_bus_overcurrent;
      fault_status_zero_d[`CSF_F0_BAT_OC_BIT]  = battery_overcurrent;
      fault_status_zero_d[`CSF_F0_CONV_OC_BIT] = converter_overcurrent;
      fault_status_zero_d[`CSF_F0_ALT2_OV_BIT] = alt_input2_overvoltage;
      fault_status_zero_d[`CSF_F0_ALT1_OV_BIT] = alt_input1_overvoltage;
   end

   // The first status register samples its conditions every cycle.
   // Nothing is latched: a bit falls at the first clock edge after its condition does.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         charger_status_three_q <= `CSF_RESET_VALUE;
      end else begin
         charger_status_three_q <= charger_status_three_d;
      end
   end

   // The thermistor zone register samples its zones every cycle.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         thermistor_zone_status_q <= `CSF_RESET_VALUE;
      end else begin
         thermistor_zone_status_q <= thermistor_zone_status_d;
      end
   end

   // The fault status register samples its faults every cycle.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fault_status_zero_q <= `CSF_RESET_VALUE;
      end else begin
         fault_status_zero_q <= fault_status_zero_d;
      end
   end

   // Access port: reads copy a register out, writes are refused.
   // The registers have no write path, so a write cannot alter them.
   csf_read_port u_read_port (
      .clk_sys       (clk_sys),
      .rst_n         (rst_n),
      .reg_rd_en     (reg_rd_en),
      .reg_wr_en     (reg_wr_en),
      .reg_addr      (reg_addr),
      .status_three  (charger_status_three_q),
      .zone_status   (thermistor_zone_status_q),
      .fault_zero    (fault_status_zero_q),
      .reg_rd_data_q (reg_rd_data_q),
      .reg_ack_q     (reg_ack_q),
      .reg_err_q     (reg_err_q)
   );

   // All checks below run on the system clock and pause in reset.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // A clean read of the first status register.
   sequence s_read_status;
      reg_rd_en && !reg_wr_en && reg_addr == `CSF_OFS_CHARGER_STATUS_THREE;
   endsequence

   // A clean read of the fault status register.
   sequence s_read_fault;
      reg_rd_en && !reg_wr_en && reg_addr == `CSF_OFS_FAULT_STATUS_ZERO;
   endsequence

   // Any write attempt.
   sequence s_write;
      reg_wr_en;
   endsequence

   // A clean read of the thermistor zone register.
   sequence s_read_zone;
      reg_rd_en && !reg_wr_en && reg_addr == `CSF_OFS_THERMISTOR_ZONE;
   endsequence

   // A read of an address that maps to no register.
   sequence s_read_unmapped;
      reg_rd_en && !reg_wr_en && reg_addr != `CSF_OFS_CHARGER_STATUS_THREE
         && reg_addr != `CSF_OFS_THERMISTOR_ZONE && reg_addr != `CSF_OFS_FAULT_STATUS_ZERO;
   endsequence

   // Second pair fitted shows one cycle later.
   property p_pair2;
      1'b1 |=> charger_status_three_q[`CSF_S3_PAIR2_BIT] == $past(input2_blocking_pair_fitted);
   endproperty
   a_pair2: assert property (p_pair2) else $error("pair 2 bit wrong");

   // First pair fitted shows one cycle later.
   property p_pair1;
      input1_blocking_pair_fitted |=> charger_status_three_q[`CSF_S3_PAIR1_BIT];
   endproperty
   a_pair1: assert property (p_pair1) else $error("pair 1 bit not set");

   // Completion outside one-shot mode reads zero.
   property p_adc_done;
      !adc_one_shot_mode || !adc_conversion_complete |=> !charger_status_three_q[`CSF_S3_ADC_DONE_BIT];
   endproperty
   a_adc_done: assert property (p_adc_done) else $error("conversion bit set wrongly");

   // Forward mode with active regulation sets the minimum regulation bit one cycle later.
   property p_min_sys;
      converter_forward_mode && min_system_regulation_active
         |=> charger_status_three_q[`CSF_S3_MIN_SYS_BIT];
   endproperty
   a_min_sys: assert property (p_min_sys) else $error("min system bit not set");

   // Fast timer expiry follows its condition.
   property p_fast_tmr;
      $rose(fast_charge_timer_expired) |=> $rose(charger_status_three_q[`CSF_S3_FAST_TMR_BIT]);
   endproperty
   a_fast_tmr: assert property (p_fast_tmr) else $error("fast timer bit late");

   // Trickle timer expiry follows its condition.
   property p_trickle;
      1'b1 |=> charger_status_three_q[`CSF_S3_TRICKLE_BIT] == $past(trickle_timer_expired);
   endproperty
   a_trickle: assert property (p_trickle) else $error("trickle bit wrong");

   // Pre-charge timer expiry follows its condition.
   property p_prechg;
      !precharge_timer_expired |=> !charger_status_three_q[`CSF_S3_PRECHG_BIT];
   endproperty
   a_prechg: assert property (p_prechg) else $error("pre-charge bit stuck");

   // Each zone bit tracks its live zone flag.
   property p_cold;
      1'b1 |=> thermistor_zone_status_q[`CSF_TZ_COLD_BIT] == $past(thermistor_cold_zone);
   endproperty
   a_cold: assert property (p_cold) else $error("cold bit wrong");

   property p_cool;
      thermistor_cool_zone |=> thermistor_zone_status_q[`CSF_TZ_COOL_BIT];
   endproperty
   a_cool: assert property (p_cool) else $error("cool bit not set");

   property p_warm;
      $fell(thermistor_warm_zone) |=> !thermistor_zone_status_q[`CSF_TZ_WARM_BIT];
   endproperty
   a_warm: assert property (p_warm) else $error("warm bit stuck");

   property p_hot;
      1'b1 |=> thermistor_zone_status_q[`CSF_TZ_HOT_BIT] == $past(thermistor_hot_zone);
   endproperty
   a_hot: assert property (p_hot) else $error("hot bit wrong");

   // The whole fault byte mirrors its inputs in bit order.
   property p_fault_byte;
      1'b1 |=> fault_status_zero_q == $past({discharge_current_regulating, input_bus_overvoltage,
         battery_overvoltage, input_bus_overcurrent, battery_overcurrent, converter_overcurrent,
         alt_input2_overvoltage, alt_input1_overvoltage});
   endproperty
   a_fault_byte: assert property (p_fault_byte) else $error("fault byte wrong");

   // Overcurrent and alternate-input overvoltage bits each follow their own condition.
   property p_bus_oc;
      input_bus_overcurrent |=> fault_status_zero_q[`CSF_F0_BUS_OC_BIT];
   endproperty
   a_bus_oc: assert property (p_bus_oc) else $error("bus overcurrent bit not set");

   property p_bat_oc;
      !battery_overcurrent |=> !fault_status_zero_q[`CSF_F0_BAT_OC_BIT];
   endproperty
   a_bat_oc: assert property (p_bat_oc) else $error("battery overcurrent bit stuck");

   property p_conv_oc;
      converter_overcurrent |=> fault_status_zero_q[`CSF_F0_CONV_OC_BIT];
   endproperty
   a_conv_oc: assert property (p_conv_oc) else $error("converter overcurrent bit not set");

   property p_alt2;
      alt_input2_overvoltage ##1 !alt_input2_overvoltage |=> !fault_status_zero_q[`CSF_F0_ALT2_OV_BIT];
   endproperty
   a_alt2: assert property (p_alt2) else $error("alt input 2 bit stuck");

   property p_alt1;
      alt_input1_overvoltage |=> fault_status_zero_q[`CSF_F0_ALT1_OV_BIT];
   endproperty
   a_alt1: assert property (p_alt1) else $error("alt input 1 bit not set");

   // Writes never disturb the registers; they only follow inputs.
   property p_write_ignored;
      s_write ##0 charger_status_three_d == charger_status_three_q
         |=> $stable(charger_status_three_q) && reg_err_q;
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("write took effect");

   // Reserved bits read zero in both registers that have them.
   property p_reserved;
      (charger_status_three_q & `CSF_S3_RSVD_MASK) == `CSF_RESET_VALUE
         && (thermistor_zone_status_q & `CSF_TZ_RSVD_MASK) == `CSF_RESET_VALUE;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   // A status read returns the register image of the request cycle.
   property p_read_status;
      logic [7:0] v;
      (s_read_status, v = charger_status_three_q) |=> reg_ack_q && !reg_err_q && reg_rd_data_q == v;
   endproperty
   a_read_status: assert property (p_read_status) else $error("status read wrong");

   // Two reads in a row return the same value when inputs hold still.
   property p_read_no_side_effect;
      s_read_fault ##1 (s_read_fault and ($stable(fault_status_zero_d) && $stable(fault_status_zero_q)))
         |=> $stable(reg_rd_data_q);
   endproperty
   a_read_no_side_effect: assert property (p_read_no_side_effect) else $error("read changed value");

   // The whole first status byte, both gated bits and the clear reserved bit.
   property p_status_byte;
      1'b1 |=> charger_status_three_q == $past({input2_blocking_pair_fitted, input1_blocking_pair_fitted,
         adc_one_shot_mode & adc_conversion_complete, converter_forward_mode & min_system_regulation_active,
         fast_charge_timer_expired, trickle_timer_expired, precharge_timer_expired, 1'b0});
   endproperty
   a_status_byte: assert property (p_status_byte) else $error("status byte wrong");

   // A zone read returns the zone image of the request cycle.
   property p_read_zone;
      logic [7:0] v;
      (s_read_zone, v = thermistor_zone_status_q) |=> reg_ack_q && !reg_err_q && reg_rd_data_q == v;
   endproperty
   a_read_zone: assert property (p_read_zone) else $error("zone read wrong");

   // A fault read returns the fault image of the request cycle.
   property p_read_fault;
      logic [7:0] v;
      (s_read_fault, v = fault_status_zero_q) |=> reg_ack_q && !reg_err_q && reg_rd_data_q == v;
   endproperty
   a_read_fault: assert property (p_read_fault) else $error("fault read wrong");

   // An unmapped read is answered with an error and empty data.
   property p_read_unmapped;
      s_read_unmapped |=> reg_ack_q && reg_err_q && reg_rd_data_q == `CSF_EMPTY_DATA;
   endproperty
   a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read wrong");

   // A write is answered with an error and leaves the read data alone.
   property p_write_refused;
      s_write |=> reg_ack_q && reg_err_q && $stable(reg_rd_data_q);
   endproperty
   a_write_refused: assert property (p_write_refused) else $error("write not refused");

   // An idle cycle is never acknowledged, so each access gets one answer.
   property p_ack_single;
      !reg_rd_en && !reg_wr_en |=> !reg_ack_q;
   endproperty
   a_ack_single: assert property (p_ack_single) else $error("stray acknowledge");

endmodule : csf_status_regs
`default_nettype wire

// [csf_status_cfg.svh]
`ifndef CSF_STATUS_CFG_SVH
`define CSF_STATUS_CFG_SVH

// Register offsets on the register access port.
`define CSF_OFS_CHARGER_STATUS_THREE 8'h1E
`define CSF_OFS_THERMISTOR_ZONE      8'h1F
`define CSF_OFS_FAULT_STATUS_ZERO    8'h20

// Reset value of all three status registers.
`define CSF_RESET_VALUE 8'h00

// Read data returned for a clean read of an unmapped address.
`define CSF_EMPTY_DATA 8'h00

// Field positions of the first status register.
`define CSF_S3_PAIR2_BIT     7
`define CSF_S3_PAIR1_BIT     6
`define CSF_S3_ADC_DONE_BIT  5
`define CSF_S3_MIN_SYS_BIT   4
`define CSF_S3_FAST_TMR_BIT  3
`define CSF_S3_TRICKLE_BIT   2
`define CSF_S3_PRECHG_BIT    1
`define CSF_S3_RSVD_MASK     8'h01

// Field positions of the thermistor zone register.
`define CSF_TZ_COLD_BIT      3
`define CSF_TZ_COOL_BIT      2
`define CSF_TZ_WARM_BIT      1
`define CSF_TZ_HOT_BIT       0
`define CSF_TZ_RSVD_MASK     8'hF0

// Field positions of the first fault status register.
`define CSF_F0_DIS_REG_BIT   7
`define CSF_F0_BUS_OV_BIT    6
`define CSF_F0_BAT_OV_BIT    5
`define CSF_F0_BUS_OC_BIT    4
`define CSF_F0_BAT_OC_BIT    3
`define CSF_F0_CONV_OC_BIT   2
`define CSF_F0_ALT2_OV_BIT   1
`define CSF_F0_ALT1_OV_BIT   0

`endif

// [csf_pkg.sv]
`default_nettype none
`include "csf_status_cfg.svh"

package csf_pkg;

   // One-hot selection of the register addressed by an access.
   typedef enum logic [3:0] {
      CSF_SEL_NONE   = 4'h1,
      CSF_SEL_STATUS = 4'h2,
      CSF_SEL_ZONE   = 4'h4,
      CSF_SEL_FAULT  = 4'h8
   } csf_sel_t;

   // Maps a register address to the register it selects.
   function automatic csf_sel_t csf_decode(input logic [7:0] addr);
      case (addr)
         `CSF_OFS_CHARGER_STATUS_THREE: csf_decode = CSF_SEL_STATUS;
         `CSF_OFS_THERMISTOR_ZONE:      csf_decode = CSF_SEL_ZONE;
         `CSF_OFS_FAULT_STATUS_ZERO:    csf_decode = CSF_SEL_FAULT;
         default:                       csf_decode = CSF_SEL_NONE;
      endcase
   endfunction : csf_decode

endpackage : csf_pkg
`default_nettype wire

// [csf_read_port.sv]
`timescale 1ns/10ps
`default_nettype none
`include "csf_status_cfg.svh"

// Answers register accesses one cycle after they are presented.
module csf_read_port (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       reg_rd_en,
   input  wire logic       reg_wr_en,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] status_three,
   input  wire logic [7:0] zone_status,
   input  wire logic [7:0] fault_zero,
   output var  logic [7:0] reg_rd_data_q,
   output var  logic       reg_ack_q,
   output var  logic       reg_err_q
);

   // Register selected by the address of the current access.
   csf_pkg::csf_sel_t sel;

   // The decode is shared by the data select and the error check.
   assign sel = csf_pkg::csf_decode(reg_addr);

   // Read data is loaded on a clean read and held until the next one.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rd_data_q <= `CSF_RESET_VALUE;
      end else if (reg_rd_en && !reg_wr_en) begin
         // Reading only copies a value, it never changes one.
         unique case (sel)
            csf_pkg::CSF_SEL_STATUS: reg_rd_data_q <= status_three;
            csf_pkg::CSF_SEL_ZONE:   reg_rd_data_q <= zone_status;
            csf_pkg::CSF_SEL_FAULT:  reg_rd_data_q <= fault_zero;
            csf_pkg::CSF_SEL_NONE:   reg_rd_data_q <= `CSF_EMPTY_DATA;
         endcase
      end
   end

   // Every access is acknowledged for exactly one cycle.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_ack_q <= 1'b0;
      end else begin
         reg_ack_q <= reg_rd_en | reg_wr_en;
      end
   end

   // Writes are refused and unmapped addresses flagged.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_err_q <= 1'b0;
      end else begin
         reg_err_q <= reg_wr_en | (reg_rd_en && sel == csf_pkg::CSF_SEL_NONE);
      end
   end

endmodule : csf_read_port
`default_nettype wire

// [csf_host_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Host side of the register port: presents one access at a time, a one-cycle request, and collects its answer.
module csf_host_model (
   input  wire logic       clk_sys,
   output var  logic       reg_rd_en,
   output var  logic       reg_wr_en,
   output var  logic [7:0] reg_addr,
   input  wire logic [7:0] reg_rd_data_q,
   input  wire logic       reg_ack_q,
   input  wire logic       reg_err_q
);
   // The port starts idle with an address that selects nothing in particular.
   initial begin
      reg_rd_en = 1'b0;
      reg_wr_en = 1'b0;
      reg_addr  = 8'h00;
   end

   // Drives one request for a single cycle, then waits a bounded time for the acknowledge.
   task automatic access(input logic wr, input logic [7:0] a, output logic [7:0] d,
                         output logic e, output logic ok);
      ok = 1'b0;
      d  = 8'h00;
      e  = 1'b0;
      @(negedge clk_sys);
      reg_rd_en <= !wr;
      reg_wr_en <= wr;
      reg_addr  <= a;
      // The request is a one-cycle pulse, so it is dropped after the edge that took it.
      @(negedge clk_sys);
      reg_rd_en <= 1'b0;
      reg_wr_en <= 1'b0;
      // A released address shows the inverse so a stale value is never mistaken for a held one.
      reg_addr  <= ~a;
      for (int n = 0; n < 4; n++) begin
         if (reg_ack_q === 1'b1) begin
            d  = reg_rd_data_q;
            e  = reg_err_q;
            ok = 1'b1;
            break;
         end
         @(negedge clk_sys);
      end
   endtask : access
endmodule : csf_host_model
`default_nettype wire

// [csf_status_regs_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "csf_status_cfg.svh"

// Self-checking bench: drives live conditions and reads the three status registers.
module csf_status_regs_tb_top;
   logic       clk_sys;                // System clock.
   logic       rst_n;                  // Synchronous reset, active low.
   logic       reg_rd_en;              // Read request from the host model.
   logic       reg_wr_en;              // Write request from the host model.
   logic [7:0] reg_addr;               // Access address.
   logic [7:0] reg_rd_data_q;          // Read data.
   logic       reg_ack_q;              // Acknowledge.
   logic       reg_err_q;              // Error flag.
   logic [7:0] s3_in;                  // Conditions for the first status register, bit 0 unused.
   logic [7:0] tz_in;                  // Zone conditions in bits 3 to 0, upper bits unused.
   logic [7:0] f0_in;                  // Fault conditions.
   logic       one_shot;               // Converter in one-shot mode.
   logic       fwd;                    // Converter in forward mode.
   logic [7:0] img_s3;                 // Image of the first status register.
   logic [7:0] img_tz;                 // Image of the zone register.
   logic [7:0] img_f0;                 // Image of the fault register.
   logic [7:0] last;                   // Data of the last clean read.
   int         err_count;              // Mismatches seen.
   int         checks;                 // Comparisons made.

   // Free-running clock at 125 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   csf_host_model csf_host_model_i (.clk_sys(clk_sys), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
      .reg_addr(reg_addr), .reg_rd_data_q(reg_rd_data_q), .reg_ack_q(reg_ack_q), .reg_err_q(reg_err_q));

   csf_status_regs csf_status_regs_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_rd_en(reg_rd_en),
      .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_rd_data_q(reg_rd_data_q), .reg_ack_q(reg_ack_q),
      .reg_err_q(reg_err_q), .input2_blocking_pair_fitted(s3_in[7]), .input1_blocking_pair_fitted(s3_in[6]),
      .adc_one_shot_mode(one_shot), .adc_conversion_complete(s3_in[5]), .converter_forward_mode(fwd),
      .min_system_regulation_active(s3_in[4]), .fast_charge_timer_expired(s3_in[3]),
      .trickle_timer_expired(s3_in[2]), .precharge_timer_expired(s3_in[1]),
      .thermistor_cold_zone(tz_in[3]), .thermistor_cool_zone(tz_in[2]), .thermistor_warm_zone(tz_in[1]),
      .thermistor_hot_zone(tz_in[0]), .discharge_current_regulating(f0_in[7]),
      .input_bus_overvoltage(f0_in[6]), .battery_overvoltage(f0_in[5]), .input_bus_overcurrent(f0_in[4]),
      .battery_overcurrent(f0_in[3]), .converter_overcurrent(f0_in[2]), .alt_input2_overvoltage(f0_in[1]),
      .alt_input1_overvoltage(f0_in[0]), .charger_status_three_q(img_s3),
      .thermistor_zone_status_q(img_tz), .fault_status_zero_q(img_f0));

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   // Compares one byte and reports a mismatch at once.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Performs one access and checks error flag and data; a lost acknowledge ends the run.
   task automatic acc(input logic wr, input logic [7:0] a, input logic ex_e, input logic [7:0] ex_d);
      logic [7:0] d;
      logic       e;
      logic       ok;
      csf_host_model_i.access(wr, a, d, e, ok);
      if (!ok) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
         test_done();
      end else begin
         chk({7'h00, e}, {7'h00, ex_e});
         chk(d, ex_d);
      end
   endtask : acc

   // Reads all three registers and compares reads and images with values built from the inputs.
   task automatic check_all;
      logic [7:0] es3;
      logic [7:0] etz;
      es3 = {s3_in[7:6], s3_in[5] & one_shot, s3_in[4] & fwd, s3_in[3:1], 1'b0};
      etz = {4'h0, tz_in[3:0]};
      acc(1'b0, `CSF_OFS_CHARGER_STATUS_THREE, 1'b0, es3);
      acc(1'b0, `CSF_OFS_THERMISTOR_ZONE, 1'b0, etz);
      acc(1'b0, `CSF_OFS_FAULT_STATUS_ZERO, 1'b0, f0_in);
      chk(img_s3, es3);
      chk(img_tz, etz);
      chk(img_f0, f0_in);
      last = f0_in;
   endtask : check_all

   // Holds reset for two cycles with every condition active; the registers must stay clear.
   task automatic do_reset;
      @(negedge clk_sys);
      rst_n = 1'b0;
      {s3_in, tz_in, f0_in, one_shot, fwd} = '1;
      repeat (2) @(negedge clk_sys);
      chk(img_s3, `CSF_RESET_VALUE);
      chk(img_tz, `CSF_RESET_VALUE);
      chk(img_f0, `CSF_RESET_VALUE);
      chk({6'h00, reg_err_q, reg_ack_q}, 8'h00);
      chk(reg_rd_data_q, `CSF_RESET_VALUE);
      rst_n = 1'b1;
   endtask : do_reset

   // Main sequence of scenarios.
   initial begin
      logic [7:0] bad [4];
      err_count = 0;
      checks    = 0;
      rst_n     = 1'b0;
      {s3_in, tz_in, f0_in, one_shot, fwd} = '0;
      last      = 8'h00;
      bad       = '{8'h00, 8'h1D, 8'h21, 8'hFF};
      do_reset();
      // All conditions active: reserved positions must still read zero.
      check_all();
      // One condition at a time across every field of every register.
      for (int r = 0; r < 3; r++) begin
         for (int b = 0; b < 8; b++) begin
            @(negedge clk_sys);
            {s3_in, tz_in, f0_in} = '0;
            one_shot = 1'b1;
            fwd      = 1'b1;
            if (r == 0) s3_in = 8'h01 << b;
            if (r == 1) tz_in = 8'h01 << b;
            if (r == 2) f0_in = 8'h01 << b;
            check_all();
         end
      end
      // Conversion-done and minimum-system bits only count in their modes.
      for (int k = 0; k < 4; k++) begin
         @(negedge clk_sys);
         s3_in    = 8'h30;
         one_shot = k[0];
         fwd      = k[1];
         check_all();
      end
      // Conditions that clear are not latched, and repeated reads change nothing.
      @(negedge clk_sys);
      {s3_in, tz_in, f0_in} = {8'hFE, 8'h0F, 8'hFF};
      check_all();
      check_all();
      @(negedge clk_sys);
      {s3_in, tz_in, f0_in} = '0;
      check_all();
      // Writes are refused, leave read data alone and do not alter any register.
      @(negedge clk_sys);
      {s3_in, tz_in, f0_in} = {8'h8A, 8'h05, 8'hA5};
      check_all();
      acc(1'b1, `CSF_OFS_CHARGER_STATUS_THREE, 1'b1, last);
      acc(1'b1, `CSF_OFS_THERMISTOR_ZONE, 1'b1, last);
      acc(1'b1, `CSF_OFS_FAULT_STATUS_ZERO, 1'b1, last);
      check_all();
      // Unmapped addresses answer with an error and empty data.
      foreach (bad[i]) begin
         acc(1'b0, bad[i], 1'b1, `CSF_EMPTY_DATA);
      end
      // A second reset in mid-run clears the registers again.
      do_reset();
      {s3_in, tz_in, f0_in, one_shot, fwd} = '0;
      check_all();
      test_done();
   end
endmodule : csf_status_regs_tb_top
`default_nettype wire
